// ===== smau_pkg.sv
package smau_pkg;
  localparam int unsigned SMAU_CLK_HZ = 40000000;
  localparam logic [31:0] SMAU_MASK_W = 32'hFFFFFFFC;
  localparam logic [31:0] SMAU_MASK_L = 32'hFFFFFFF8;
  localparam logic [31:0] SMAU_MASK_Q = 32'hFFFFFFF0;
  localparam logic [31:0] SMAU_ICR_ADDR = 32'hFF000004;
  localparam logic [31:0] SMAU_MSG_ADDR = 32'hFF000010;
  localparam logic [31:0] SMAU_WORD_BYTES = 32'h00000004;
  localparam logic [2:0] SMAU_CC_OK = 3'h2;
  localparam logic [2:0] SMAU_CC_BAD = 3'h0;
  localparam logic [2:0] SMAU_CNT_W = 3'h1;
  localparam logic [2:0] SMAU_CNT_L = 3'h2;
  localparam logic [2:0] SMAU_CNT_Q = 3'h4;

  typedef enum logic [2:0] {SMAU_OP_SYNLD, SMAU_OP_MOV, SMAU_OP_MOVL, SMAU_OP_MOVQ, SMAU_OP_SYNCF} smau_op_t;

  typedef struct packed {
    smau_op_t op;
    logic [31:0] src;
    logic [31:0] dst;
  } smau_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic noncache;
    logic [31:0] addr;
    logic [31:0] wdata;
  } smau_bus_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } smau_bus_rsp_t;
endpackage

// ===== smau_xlate.sv
`timescale 1ns/1ps
module smau_xlate
  import smau_pkg::*;
(
  input wire logic physical_mode,
  input wire logic [31:0] operand,
  input wire logic [31:0] xlat_addr,
  input wire logic [31:0] mask,
  output logic [31:0] aligned
);
  // Translation result used only outside physical mode; alignment after
  always_comb
  begin
    aligned = (physical_mode ? operand : xlat_addr) & mask;
  end
endmodule

// ===== smau_count.sv
`timescale 1ns/1ps
module smau_count
  import smau_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [2:0] load_val,
  input wire logic dec,
  output logic [2:0] count
);
  logic [2:0] next_count;
  always_comb
  begin
    next_count = count;
    if (load)
    begin
      next_count = load_val;
    end
    else if (dec && count != 3'h0)
    begin
      next_count = count - 3'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= 3'h0;
    end
    else
    begin
      count <= next_count;
    end
  end
endmodule

// ===== smau_core.sv
`timescale 1ns/1ps
module smau_core
  import smau_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire smau_pkg::smau_req_t req,
  input wire logic physical_mode,
  input wire logic [31:0] src_xlat,
  input wire logic [31:0] dst_xlat,
  input wire logic imprecise_allowed,
  input wire logic imprecise_pending,
  input wire logic ops_outstanding,
  input wire logic [31:0] int_ctrl_reg,
  input wire smau_pkg::smau_bus_rsp_t bus_rsp,
  output smau_pkg::smau_bus_req_t bus_req,
  output logic stall,
  output logic done,
  output logic [2:0] condition_code_field,
  output logic cc_write,
  output logic [31:0] load_data,
  output logic load_data_valid,
  output logic icr_write,
  output logic [31:0] icr_wdata,
  output logic msg_valid,
  output logic [31:0] msg_data,
  output logic [1:0] msg_index
);
  import smau_pkg::*;

  typedef enum logic [2:0] {SMAU_IDLE, SMAU_RD, SMAU_WR, SMAU_DRAIN, SMAU_FSYNC} smau_state_t;

  function automatic logic [31:0] smau_mask(input smau_op_t op);
    case (op)
      SMAU_OP_MOVL: smau_mask = SMAU_MASK_L;
      SMAU_OP_MOVQ: smau_mask = SMAU_MASK_Q;
      default: smau_mask = SMAU_MASK_W;
    endcase
  endfunction

  smau_state_t state, next_state;
  smau_op_t op, next_op;
  logic [31:0] saddr, next_saddr;
  logic [31:0] daddr, next_daddr;
  logic [31:0] word, next_word;
  logic bad, next_bad;
  logic self_msg, next_self_msg;
  logic [1:0] idx, next_idx;
  smau_bus_req_t next_bus_req;
  logic next_stall, next_done, next_cc_write, next_ld_valid, next_icr_write, next_msg_valid;
  logic [2:0] next_cc;
  logic [31:0] next_load_data, next_icr_wdata, next_msg_data;
  logic [1:0] next_msg_index;
  logic [31:0] src_al, dst_al;
  logic [2:0] remaining;
  logic cnt_load, cnt_dec;
  logic [2:0] cnt_val;
  logic last;

  smau_xlate u_src (.physical_mode(physical_mode), .operand(req.src), .xlat_addr(src_xlat),
    .mask(smau_mask(req.op)), .aligned(src_al));
  smau_xlate u_dst (.physical_mode(physical_mode), .operand(req.dst), .xlat_addr(dst_xlat),
    .mask(smau_mask(req.op)), .aligned(dst_al));
  smau_count u_cnt (.clk(clk), .rst(rst), .load(cnt_load), .load_val(cnt_val), .dec(cnt_dec),
    .count(remaining));

  assign last = (remaining == 3'h1);

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_saddr = saddr;
    next_daddr = daddr;
    next_word = word;
    next_bad = bad;
    next_self_msg = self_msg;
    next_idx = idx;
    next_bus_req = '0;
    next_stall = stall;
    next_done = 1'b0;
    next_cc_write = 1'b0;
    next_cc = condition_code_field;
    next_ld_valid = 1'b0;
    next_load_data = load_data;
    next_icr_write = 1'b0;
    next_icr_wdata = icr_wdata;
    next_msg_valid = 1'b0;
    next_msg_data = msg_data;
    next_msg_index = msg_index;
    cnt_load = 1'b0;
    cnt_dec = 1'b0;
    cnt_val = SMAU_CNT_W;
    case (state)
      SMAU_IDLE:
      begin
        if (req_valid)
        begin
          next_op = req.op;
          next_saddr = src_al;
          next_daddr = dst_al;
          next_bad = 1'b0;
          next_idx = 2'h0;
          next_stall = 1'b1;
          // Only moves deliver messages; a load must never mask a bad access
          next_self_msg = (dst_al == SMAU_MSG_ADDR) &&
            (req.op inside {SMAU_OP_MOV, SMAU_OP_MOVL, SMAU_OP_MOVQ});
          cnt_load = 1'b1;
          case (req.op)
            SMAU_OP_MOVL: cnt_val = SMAU_CNT_L;
            SMAU_OP_MOVQ: cnt_val = SMAU_CNT_Q;
            default: cnt_val = SMAU_CNT_W;
          endcase
          if (req.op == SMAU_OP_SYNCF)
          begin
            next_state = SMAU_FSYNC;
          end
          else if (req.op == SMAU_OP_SYNLD && src_al == SMAU_ICR_ADDR)
          begin
            next_load_data = int_ctrl_reg;
            next_ld_valid = 1'b1;
            next_cc = SMAU_CC_OK;
            next_cc_write = 1'b1;
            next_done = 1'b1;
            next_stall = 1'b0;
          end
          else
          begin
            next_state = SMAU_RD;
            next_bus_req.valid = 1'b1;
            next_bus_req.addr = src_al;
          end
        end
      end
      SMAU_RD:
      begin
        if (bus_rsp.done)
        begin
          next_word = bus_rsp.rdata;
          next_bad = bad | bus_rsp.err;
          if (op == SMAU_OP_SYNLD)
          begin
            next_load_data = bus_rsp.rdata;
            next_ld_valid = 1'b1;
            next_state = SMAU_DRAIN;
          end
          else if (op == SMAU_OP_MOV && daddr == SMAU_ICR_ADDR)
          begin
            next_icr_write = 1'b1;
            next_icr_wdata = bus_rsp.rdata;
            next_state = SMAU_DRAIN;
          end
          else if (self_msg)
          begin
            next_msg_valid = 1'b1;
            next_msg_data = bus_rsp.rdata;
            next_msg_index = idx;
            cnt_dec = 1'b1;
            next_idx = idx + 2'h1;
            next_saddr = saddr + SMAU_WORD_BYTES;
            if (last)
            begin
              next_state = SMAU_DRAIN;
            end
            else
            begin
              next_bus_req.valid = 1'b1;
              next_bus_req.addr = saddr + SMAU_WORD_BYTES;
            end
          end
          else
          begin
            next_state = SMAU_WR;
            next_bus_req.valid = 1'b1;
            next_bus_req.write = 1'b1;
            next_bus_req.noncache = 1'b1;
            next_bus_req.addr = daddr;
            next_bus_req.wdata = bus_rsp.rdata;
          end
        end
        else
        begin
          next_bus_req = bus_req;
        end
      end
      SMAU_WR:
      begin
        if (bus_rsp.done)
        begin
          next_bad = bad | bus_rsp.err;
          cnt_dec = 1'b1;
          next_saddr = saddr + SMAU_WORD_BYTES;
          next_daddr = daddr + SMAU_WORD_BYTES;
          if (last)
          begin
            next_state = SMAU_DRAIN;
          end
          else
          begin
            next_state = SMAU_RD;
            next_bus_req.valid = 1'b1;
            next_bus_req.addr = saddr + SMAU_WORD_BYTES;
          end
        end
        else
        begin
          next_bus_req = bus_req;
        end
      end
      SMAU_DRAIN:
      begin
        // Earlier posted operations must settle too, not only ours
        if (!ops_outstanding)
        begin
          next_cc = (bad && !self_msg) ? SMAU_CC_BAD : SMAU_CC_OK;
          next_cc_write = 1'b1;
          next_done = 1'b1;
          next_stall = 1'b0;
          next_state = SMAU_IDLE;
        end
      end
      SMAU_FSYNC:
      begin
        if (!(imprecise_allowed && imprecise_pending))
        begin
          next_done = 1'b1;
          next_stall = 1'b0;
          next_state = SMAU_IDLE;
        end
      end
      default: next_state = SMAU_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= SMAU_IDLE;
      op <= SMAU_OP_SYNLD;
      saddr <= 32'h0;
      daddr <= 32'h0;
      word <= 32'h0;
      bad <= 1'b0;
      self_msg <= 1'b0;
      idx <= 2'h0;
      bus_req <= '0;
      stall <= 1'b0;
      done <= 1'b0;
      condition_code_field <= SMAU_CC_BAD;
      cc_write <= 1'b0;
      load_data <= 32'h0;
      load_data_valid <= 1'b0;
      icr_write <= 1'b0;
      icr_wdata <= 32'h0;
      msg_valid <= 1'b0;
      msg_data <= 32'h0;
      msg_index <= 2'h0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      saddr <= next_saddr;
      daddr <= next_daddr;
      word <= next_word;
      bad <= next_bad;
      self_msg <= next_self_msg;
      idx <= next_idx;
      bus_req <= next_bus_req;
      stall <= next_stall;
      done <= next_done;
      condition_code_field <= next_cc;
      cc_write <= next_cc_write;
      load_data <= next_load_data;
      load_data_valid <= next_ld_valid;
      icr_write <= next_icr_write;
      icr_wdata <= next_icr_wdata;
      msg_valid <= next_msg_valid;
      msg_data <= next_msg_data;
      msg_index <= next_msg_index;
    end
  end

  a_bad_gives_zero: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_DRAIN && !ops_outstanding && bad && !self_msg) |=> (condition_code_field == SMAU_CC_BAD && cc_write))
    else $error("bad access did not give cc 000");
  a_ok_gives_010: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_DRAIN && !ops_outstanding && !bad) |=> (condition_code_field == SMAU_CC_OK && done))
    else $error("success did not give cc 010");
  a_stall_drain: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_DRAIN && ops_outstanding) |=> stall)
    else $error("stall dropped before drain");
  a_move_noncache: assert property (@(posedge clk) disable iff (rst)
    (bus_req.valid && bus_req.write) |-> bus_req.noncache)
    else $error("move write cacheable");
  a_word_align: assert property (@(posedge clk) disable iff (rst)
    (bus_req.valid && op != SMAU_OP_SYNCF) |-> (bus_req.addr[1:0] == 2'h0))
    else $error("bus address not word aligned");
  a_icr_load: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_IDLE && req_valid && req.op == SMAU_OP_SYNLD && src_al == SMAU_ICR_ADDR)
    |=> (load_data == $past(int_ctrl_reg) && condition_code_field == SMAU_CC_OK && !bus_req.valid))
    else $error("interrupt control load wrong");
  a_msg_no_write: assert property (@(posedge clk) disable iff (rst)
    self_msg && state != SMAU_IDLE |-> !(bus_req.valid && bus_req.write))
    else $error("self message written to memory");
  a_move_data: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_WR && bus_req.valid) |-> (bus_req.wdata == word))
    else $error("move write data differs from word read");
  a_fsync_wait: assert property (@(posedge clk) disable iff (rst)
    (state == SMAU_FSYNC && imprecise_allowed && imprecise_pending) |=> (state == SMAU_FSYNC && !done))
    else $error("fault sync released early");
endmodule

// ===== smau_mem_model.sv
`timescale 1ns/1ps
module smau_mem_model
  import smau_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire smau_pkg::smau_bus_req_t bus_req,
  output smau_pkg::smau_bus_rsp_t bus_rsp
);
  logic [3:0] wait_cnt;
  // Read data keyed by address; the 0xE region has no agent behind it
  always_ff @(posedge clk)
  begin
    bus_rsp.done <= 1'b0;
    // Released data toggles so stale values never look valid
    bus_rsp.rdata <= ~bus_rsp.rdata;
    if (rst)
    begin
      wait_cnt <= 4'h0;
      bus_rsp.err <= 1'b0;
      bus_rsp.rdata <= 32'h00000000;
    end
    else if (bus_req.valid && !bus_rsp.done)
    begin
      if (wait_cnt >= lat)
      begin
        wait_cnt <= 4'h0;
        bus_rsp.done <= 1'b1;
        bus_rsp.err <= (bus_req.addr[31:28] == 4'hE);
        bus_rsp.rdata <= bus_req.addr ^ 32'hC3C30000;
      end
      else
      begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// ===== smau_core_bench.sv
`timescale 1ns/1ps
module smau_core_bench;
  import smau_pkg::*;
  localparam logic [31:0] XL = 32'h00100000;
  localparam logic [31:0] ICR = 32'h13572468;
  logic clk, rst, req_valid, physical_mode, imprecise_allowed, imprecise_pending, ops_outstanding;
  logic stall, done, cc_write, load_data_valid, icr_write, msg_valid;
  smau_req_t req;
  smau_bus_req_t bus_req;
  smau_bus_rsp_t bus_rsp;
  logic [2:0] cc, cc_got;
  logic [31:0] load_data, ld_got, icr_wdata, msg_data, msg_base, icr_got;
  logic [1:0] msg_index;
  logic [3:0] lat;
  logic [64:0] wq[$];
  int fails, samples_checked, nmsg, c;

  smau_core i_smau_core (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .physical_mode(physical_mode),
    .src_xlat(req.src ^ XL), .dst_xlat(req.dst ^ XL), .imprecise_allowed(imprecise_allowed),
    .imprecise_pending(imprecise_pending), .ops_outstanding(ops_outstanding), .int_ctrl_reg(ICR),
    .bus_rsp(bus_rsp), .bus_req(bus_req), .stall(stall), .done(done), .condition_code_field(cc),
    .cc_write(cc_write), .load_data(load_data), .load_data_valid(load_data_valid), .icr_write(icr_write),
    .icr_wdata(icr_wdata), .msg_valid(msg_valid), .msg_data(msg_data), .msg_index(msg_index));
  smau_mem_model i_smau_mem_model (.clk(clk), .rst(rst), .lat(lat), .bus_req(bus_req), .bus_rsp(bus_rsp));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'hC3C30000;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    if (cc_write === 1'b1) cc_got = cc;
    if (load_data_valid === 1'b1) ld_got = load_data;
    if (icr_write === 1'b1) icr_got = icr_wdata;
    if (msg_valid === 1'b1)
    begin
      chk(msg_data, pat(msg_base + {28'h0, msg_index, 2'b00}));
      nmsg++;
    end
    if (bus_rsp.done === 1'b1 && bus_req.write === 1'b1)
      wq.push_back({bus_req.noncache, bus_req.addr, bus_req.wdata});
  end

  // Holds earlier work pending for hold cycles; stall is checked once, at the release
  task automatic run(input smau_op_t op, input logic pm, input logic [31:0] s, input logic [31:0] d,
    input int hold);
    @(negedge clk);
    physical_mode = pm;
    req = '{op, s, d};
    req_valid = 1'b1;
    ops_outstanding = (hold > 0) && (op != SMAU_OP_SYNCF);
    imprecise_pending = (hold > 0) && (op == SMAU_OP_SYNCF);
    cc_got = 3'h7;
    icr_got = 32'h0;
    nmsg = 0;
    wq.delete();
    @(negedge clk);
    req_valid = 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 300)
    begin
      if (c == hold && hold > 0)
      begin
        chk({31'h0, stall}, 32'h1);
        ops_outstanding = 1'b0;
        imprecise_pending = 1'b0;
      end
      @(negedge clk);
      c++;
    end
    ops_outstanding = 1'b0;
    imprecise_pending = 1'b0;
    // Capture block fires on the same edge as done; let it finish first
    #1;
    chk(c < 300, 1);
  endtask

  task automatic t_loads;
    run(SMAU_OP_SYNLD, 1'b1, 32'h00001237, 32'h0, 12);
    chk(ld_got, pat(32'h00001234));
    chk(cc_got, SMAU_CC_OK);
    chk(c > 12, 1);
    run(SMAU_OP_SYNLD, 1'b0, 32'h00002001, 32'h0, 0);
    chk(ld_got, pat(32'h00102000));
    run(SMAU_OP_SYNLD, 1'b1, 32'hE0000000, 32'h0, 0);
    chk(cc_got, SMAU_CC_BAD);
    run(SMAU_OP_SYNLD, 1'b1, 32'hFF000007, 32'h0, 0);
    chk(ld_got, ICR);
    chk(cc_got, SMAU_CC_OK);
  endtask

  task automatic t_moves;
    smau_op_t ops[3] = '{SMAU_OP_MOV, SMAU_OP_MOVL, SMAU_OP_MOVQ};
    logic [31:0] masks[3] = '{SMAU_MASK_W, SMAU_MASK_L, SMAU_MASK_Q};
    logic [31:0] sa, da;
    for (int k = 0; k < 3; k++)
    begin
      lat = 4'(k * 3);
      run(ops[k], 1'b0, 32'h0000300F, 32'h0000500F, 8);
      sa = (32'h0000300F ^ XL) & masks[k];
      da = (32'h0000500F ^ XL) & masks[k];
      chk(wq.size(), 1 << k);
      for (int i = 0; i < wq.size(); i++)
      begin
        chk(wq[i][63:32], da + 32'(4 * i));
        chk(wq[i][31:0], pat(sa + 32'(4 * i)));
        chk({31'h0, wq[i][64]}, 32'h1);
      end
      chk(cc_got, SMAU_CC_OK);
      chk(c > 8, 1);
    end
    run(SMAU_OP_MOV, 1'b1, 32'h00000100, 32'hE0000004, 0);
    chk(cc_got, SMAU_CC_BAD);
    run(SMAU_OP_MOV, 1'b1, 32'h00000200, 32'hFF000007, 0);
    chk(icr_got, pat(32'h00000200));
    chk(wq.size(), 0);
    chk(cc_got, SMAU_CC_OK);
  endtask

  task automatic t_msg;
    msg_base = 32'h00000700;
    run(SMAU_OP_MOVQ, 1'b1, 32'h0000070C, 32'hFF00001C, 0);
    chk(nmsg, 4);
    chk(wq.size(), 0);
    chk(cc_got, SMAU_CC_OK);
  endtask

  task automatic t_syncf;
    imprecise_allowed = 1'b1;
    run(SMAU_OP_SYNCF, 1'b1, 32'h0, 32'h0, 15);
    chk(c > 15, 1);
    imprecise_allowed = 1'b0;
    run(SMAU_OP_SYNCF, 1'b1, 32'h0, 32'h0, 15);
    chk(c < 15, 1);
  endtask

  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    physical_mode = 1'b1;
    imprecise_allowed = 1'b0;
    imprecise_pending = 1'b0;
    ops_outstanding = 1'b0;
    lat = 4'h0;
    fails = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_loads();
    t_moves();
    t_msg();
    t_syncf();
    report_and_stop();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
